// ===== logic/tm_consts.svh
// Operation
// - 16-bit count advances on internal ticks or external events per select bit; baud mode ignores the select bit and takes the fast internal tick.
// - Three modes: capture, auto-reload up or down, baud-rate generation.
// - Baud bits win; else capture select picks capture or reload; run clear stops.
// - Capture mode: count overflow sets overflow flag, which may request interrupt.
// - Capture with external enable: trigger falling edge copies count into reload pair.
// - That edge sets external flag; both flags share one interrupt request.
// - Capture mode reloads only when clock out is on; counting continues through a capture.
// - Down count enable resets to zero, so reload mode counts up.
// - Up reload: overflow past all ones sets overflow flag and reloads count.
// - Up reload with external enable: trigger falling edge also reloads, sets external flag.
// - Up reload: interrupt requested when enabled and either flag is set.
// - Down enable, trigger high: count up, overflow sets flag and reloads.
// - Down enable, trigger low: count down; at reload value set flag, load ones.
// - Down enable: external flag toggles on each wrap, never interrupts.
// - Clock out needs timer select, clock out enable and run; gives 50% square wave (pin drive enable here ignores run; only the toggling stops).
// - Clock out frequency is oscillator over four times (65536 minus reload).
// - Clock out rollovers raise no interrupt, as in baud generation.
// - Baud and clock out together share one rollover and one frequency.
// - Clock out pin doubles as external count input in counter operation.
// - Run control set starts the timer, clear stops counting.
`ifndef TM_CONSTS_SVH
`define TM_CONSTS_SVH

`define TM_OFF_CTRL 8'h00
`define TM_OFF_MODE 8'h04
`define TM_OFF_CNTL 8'h08
`define TM_OFF_CNTH 8'h0c
`define TM_OFF_RELL 8'h10
`define TM_OFF_RELH 8'h14

`define TM_B_OVF 7
`define TM_B_EXTF 6
`define TM_B_RXB 5
`define TM_B_TXB 4
`define TM_B_EXEN 3
`define TM_B_RUN 2
`define TM_B_CT 1
`define TM_B_CPRL 0
`define TM_B_CKOE 1
`define TM_B_DOWN 0

`define TM_CTRL_RST 8'h00
`define TM_MODE_RST 2'h0

`define TM_CLK_NS 40
`define TM_MC_NS 480
`define TM_MC_CYC (`TM_MC_NS / `TM_CLK_NS)

`endif

// ===== logic/tm_pkg.sv
`include "tm_consts.svh"
package tm_pkg;
    typedef enum logic [1:0] {
        TM_OFF = 2'b00,
        TM_RELOAD = 2'b01,
        TM_CAPTURE = 2'b10,
        TM_BAUD = 2'b11
    } tm_mode_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] mode_reg;
        logic [15:0] count;
        logic [15:0] reload;
        logic [3:0] presc;
        logic half;
        logic [1:0][2:0] pin_sh;
        logic clk_out;
        logic clk_oe;
        logic irq;
        logic baud_tick;
    } tm_state_t;

    typedef struct packed {
        logic awready;
        logic aw_held;
        logic [7:0] waddr;
        logic wready;
        logic w_held;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic wr_en;
        logic arready;
        logic rpend;
        logic [7:0] raddr;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } tm_axs_t;

    function automatic logic tm_reg_hit(input logic [7:0] a);
        return a == `TM_OFF_CTRL || a == `TM_OFF_MODE || a == `TM_OFF_CNTL
            || a == `TM_OFF_CNTH || a == `TM_OFF_RELL || a == `TM_OFF_RELH;
    endfunction

    function automatic tm_mode_t tm_mode_of(input logic [7:0] c);
        if (!c[`TM_B_RUN])
            return TM_OFF;
        if (c[`TM_B_RXB] || c[`TM_B_TXB])
            return TM_BAUD;
        return c[`TM_B_CPRL] ? TM_CAPTURE : TM_RELOAD;
    endfunction
endpackage

// ===== logic/tm_axil.sv
`timescale 1ns/100ps
module tm_axil import tm_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [7:0] awaddr_i,
    input wire logic wvalid_i,
    output logic wready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    output logic bvalid_o,
    input wire logic bready_i,
    output logic [1:0] bresp_o,
    input wire logic arvalid_i,
    output logic arready_o,
    input wire logic [7:0] araddr_i,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic wr_en_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic [7:0] rd_addr_o,
    input wire logic [31:0] rd_data_i
);
    localparam tm_axs_t AXS_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
    tm_axs_t s;
    tm_axs_t next_s;

    // ------------------------------------------------------------
    // Channel handshakes
    // ------------------------------------------------------------
    // Address and data are held until both are in, so either may arrive first
    always_comb
    begin
        next_s = s;
        next_s.wr_en = 1'b0;
        if (awvalid_i && s.awready)
        begin
            next_s.aw_held = 1'b1;
            next_s.waddr = awaddr_i;
            next_s.awready = 1'b0;
        end
        if (wvalid_i && s.wready)
        begin
            next_s.w_held = 1'b1;
            next_s.wdata = wdata_i[7:0];
            next_s.wstrb0 = wstrb_i[0];
            next_s.wready = 1'b0;
        end
        if (s.aw_held && s.w_held)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = tm_reg_hit(s.waddr) ? 2'h0 : 2'h2;
            next_s.wr_en = tm_reg_hit(s.waddr) && s.wstrb0;
        end
        if (s.bvalid && bready_i)
        begin
            next_s.bvalid = 1'b0;
            next_s.awready = 1'b1;
            next_s.wready = 1'b1;
        end
        if (arvalid_i && s.arready)
        begin
            next_s.arready = 1'b0;
            next_s.raddr = araddr_i;
            next_s.rpend = 1'b1;
        end
        if (s.rpend)
        begin
            next_s.rpend = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rdata = tm_reg_hit(s.raddr) ? rd_data_i : 32'h0;
            next_s.rresp = tm_reg_hit(s.raddr) ? 2'h0 : 2'h2;
        end
        if (s.rvalid && rready_i)
        begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            s <= AXS_RST;
        else
            s <= next_s;
    end

    assign awready_o = s.awready;
    assign wready_o = s.wready;
    assign bvalid_o = s.bvalid;
    assign bresp_o = s.bresp;
    assign arready_o = s.arready;
    assign rvalid_o = s.rvalid;
    assign rdata_o = s.rdata;
    assign rresp_o = s.rresp;
    assign wr_en_o = s.wr_en;
    assign wr_addr_o = s.waddr;
    assign wr_data_o = s.wdata;
    assign rd_addr_o = s.raddr;
endmodule

// ===== logic/tm_top.sv
`timescale 1ns/100ps
module tm_top import tm_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [7:0] awaddr_i,
    input wire logic wvalid_i,
    output logic wready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    output logic bvalid_o,
    input wire logic bready_i,
    output logic [1:0] bresp_o,
    input wire logic arvalid_i,
    output logic arready_o,
    input wire logic [7:0] araddr_i,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    input wire logic ext_trig_i,
    input wire logic clock_out_pin_i,
    output logic clock_out_pin_o,
    output logic clock_out_pin_oe_o,
    input wire logic irq_enable_i,
    output logic timer_irq_o,
    output logic baud_tick_o
);
    localparam logic [3:0] MC_LAST = 4'(`TM_MC_CYC - 1);
    localparam tm_state_t ST_RST = '{
        ctrl: `TM_CTRL_RST,
        mode_reg: `TM_MODE_RST,
        default: '0
    };

    tm_state_t s;
    tm_state_t next_s;
    tm_mode_t mode;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic [1:0] pin_in;
    logic [1:0] fall;
    logic run;
    logic exen;
    logic down_en;
    logic clkout;
    logic baud;
    logic fast;
    logic mc_tick;
    logic tick;
    logic down;
    logic top;
    logic ovf;
    logic unf;
    logic trig_ev;
    logic capture;
    logic reload_now;
    logic tf_set;
    logic exf_set;
    logic exf_tgl;
    logic [15:0] cnt_step;
    logic [15:0] cnt_hw;
    logic sw_wr_cnt;
    logic sw_wr_ctrl;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    tm_axil u_axil (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .awvalid_i(awvalid_i),
        .awready_o(awready_o),
        .awaddr_i(awaddr_i),
        .wvalid_i(wvalid_i),
        .wready_o(wready_o),
        .wdata_i(wdata_i),
        .wstrb_i(wstrb_i),
        .bvalid_o(bvalid_o),
        .bready_i(bready_i),
        .bresp_o(bresp_o),
        .arvalid_i(arvalid_i),
        .arready_o(arready_o),
        .araddr_i(araddr_i),
        .rvalid_o(rvalid_o),
        .rready_i(rready_i),
        .rdata_o(rdata_o),
        .rresp_o(rresp_o),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data)
    );

    // Reads have no side effects, so flags clear only by writing them, or the external flag by its toggle in down mode
    always_comb
    begin
        unique case (rd_addr)
            `TM_OFF_CTRL: rd_data = {24'h0, s.ctrl};
            `TM_OFF_MODE: rd_data = {30'h0, s.mode_reg};
            `TM_OFF_CNTL: rd_data = {24'h0, s.count[7:0]};
            `TM_OFF_CNTH: rd_data = {24'h0, s.count[15:8]};
            `TM_OFF_RELL: rd_data = {24'h0, s.reload[7:0]};
            `TM_OFF_RELH: rd_data = {24'h0, s.reload[15:8]};
            default: rd_data = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // Pin edges
    // ------------------------------------------------------------
    assign pin_in = {clock_out_pin_i, ext_trig_i};
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_edge
            assign fall[g] = s.pin_sh[g][2] & ~s.pin_sh[g][1];
        end
    endgenerate

    // ------------------------------------------------------------
    // Mode and count decode
    // ------------------------------------------------------------
    assign mode = tm_mode_of(s.ctrl);
    assign run = s.ctrl[`TM_B_RUN];
    assign exen = s.ctrl[`TM_B_EXEN];
    assign down_en = s.mode_reg[`TM_B_DOWN];
    assign baud = mode == TM_BAUD;
    assign clkout = s.mode_reg[`TM_B_CKOE] & ~s.ctrl[`TM_B_CT];
    // Baud and clock out count the same fast tick, so one rollover serves both
    assign fast = baud | clkout;
    assign mc_tick = s.presc == MC_LAST;
    assign tick = run & (fast ? s.half : (s.ctrl[`TM_B_CT] ? fall[1] : mc_tick));
    assign down = mode == TM_RELOAD && down_en && !fast && !s.pin_sh[0][1];
    assign top = s.count == 16'hffff;
    assign ovf = tick & ~down & top;
    assign unf = tick & down & (s.count == s.reload);
    assign trig_ev = fall[0] & exen & (mode != TM_OFF);
    assign cnt_step = down ? s.count - 16'h1 : s.count + 16'h1;
    assign sw_wr_cnt = wr_en && (wr_addr == `TM_OFF_CNTL || wr_addr == `TM_OFF_CNTH);
    assign sw_wr_ctrl = wr_en && wr_addr == `TM_OFF_CTRL;

    always_comb
    begin
        capture = 1'b0;
        reload_now = 1'b0;
        tf_set = 1'b0;
        exf_set = 1'b0;
        exf_tgl = 1'b0;
        unique case (mode)
            TM_OFF:
            begin
                reload_now = 1'b0;
            end
            TM_CAPTURE:
            begin
                capture = trig_ev & ~fast;
                reload_now = fast & ovf;
                tf_set = ~fast & ovf;
                exf_set = trig_ev;
            end
            TM_RELOAD:
            begin
                if (fast)
                begin
                    reload_now = ovf;
                    exf_set = trig_ev;
                end
                else if (down_en)
                begin
                    reload_now = ovf;
                    tf_set = ovf | unf;
                    exf_tgl = ovf | unf;
                end
                else
                begin
                    reload_now = ovf | trig_ev;
                    tf_set = ovf;
                    exf_set = trig_ev;
                end
            end
            TM_BAUD:
            begin
                reload_now = ovf;
                exf_set = trig_ev;
            end
        endcase
    end

    assign cnt_hw = unf ? 16'hffff : (reload_now ? s.reload : (tick ? cnt_step : s.count));

    // ------------------------------------------------------------
    // State update
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.presc = mc_tick ? 4'h0 : s.presc + 4'h1;
        next_s.half = ~s.half;
        for (int p = 0; p < 2; p++)
        begin
            next_s.pin_sh[p] = {s.pin_sh[p][1:0], pin_in[p]};
        end
        next_s.count = cnt_hw;
        // A software load of the count wins over the hardware step
        if (wr_en)
        begin
            unique case (wr_addr)
                `TM_OFF_CTRL: next_s.ctrl = wr_data;
                `TM_OFF_MODE: next_s.mode_reg = wr_data[1:0];
                `TM_OFF_CNTL: next_s.count[7:0] = wr_data;
                `TM_OFF_CNTH: next_s.count[15:8] = wr_data;
                `TM_OFF_RELL: next_s.reload[7:0] = wr_data;
                `TM_OFF_RELH: next_s.reload[15:8] = wr_data;
                default: next_s.ctrl = s.ctrl;
            endcase
        end
        // Hardware events are applied after the write so none is lost
        if (capture)
            next_s.reload = s.count;
        if (tf_set)
            next_s.ctrl[`TM_B_OVF] = 1'b1;
        if (exf_set)
            next_s.ctrl[`TM_B_EXTF] = 1'b1;
        if (exf_tgl)
            next_s.ctrl[`TM_B_EXTF] = ~next_s.ctrl[`TM_B_EXTF];
        if (clkout && ovf)
            next_s.clk_out = ~s.clk_out;
        next_s.clk_oe = clkout;
        next_s.baud_tick = baud & ovf;
        next_s.irq = irq_enable_i & (next_s.ctrl[`TM_B_OVF]
            | (next_s.ctrl[`TM_B_EXTF] & ~next_s.mode_reg[`TM_B_DOWN]));
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            s <= ST_RST;
        else
            s <= next_s;
    end

    assign clock_out_pin_o = s.clk_out;
    assign clock_out_pin_oe_o = s.clk_oe;
    assign timer_irq_o = s.irq;
    assign baud_tick_o = s.baud_tick;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_mc_gap;
        (!mc_tick)[*8] ##1 !mc_tick ##1 !mc_tick ##1 !mc_tick ##1 mc_tick;
    endsequence

    sequence s_cap_evt;
        capture && !sw_wr_ctrl;
    endsequence

    a_mc_period: assert property (mc_tick |=> s_mc_gap)
        else $error("machine cycle tick spacing wrong");

    a_cap_copy: assert property (s_cap_evt |=> s.reload == $past(s.count))
        else $error("capture did not copy count");

    a_cap_flag: assert property (s_cap_evt |=> s.ctrl[`TM_B_EXTF])
        else $error("capture did not set external flag");

    a_cap_counts: assert property ((mode == TM_CAPTURE && !fast && tick && !top && !sw_wr_cnt)
        |=> s.count == $past(s.count) + 16'h1)
        else $error("capture mode count did not advance");

    a_cap_ovf: assert property ((mode == TM_CAPTURE && !fast && ovf && !sw_wr_ctrl)
        |=> s.ctrl[`TM_B_OVF])
        else $error("overflow flag not set");

    a_up_reload: assert property ((mode == TM_RELOAD && !fast && !down_en && ovf && !sw_wr_cnt)
        |=> s.count == $past(s.reload))
        else $error("overflow did not reload count");

    a_trig_reload: assert property ((mode == TM_RELOAD && !fast && !down_en && trig_ev
        && !sw_wr_cnt) |=> s.count == $past(s.reload) ##1 1'b1)
        else $error("trigger edge did not reload count");

    a_down_wrap: assert property ((unf && !sw_wr_cnt) |=> s.count == 16'hffff)
        else $error("underflow did not load all ones");

    a_ext_toggle: assert property ((exf_tgl && !sw_wr_ctrl)
        |=> s.ctrl[`TM_B_EXTF] != $past(s.ctrl[`TM_B_EXTF]))
        else $error("external flag did not toggle");

    a_clkout_quiet: assert property ((clkout && ovf && !sw_wr_ctrl && !s.ctrl[`TM_B_OVF])
        |=> !s.ctrl[`TM_B_OVF])
        else $error("clock out rollover set overflow flag");

    a_clkout_edge: assert property ((clkout && ovf) |=> s.clk_out != $past(s.clk_out))
        else $error("clock out did not toggle on rollover");

    a_stop_hold: assert property ((!run && !sw_wr_cnt) |=> $stable(s.count))
        else $error("count moved while stopped");

    sequence s_baud_roll;
        baud && ovf;
    endsequence

    sequence s_trig_drop;
        s.pin_sh[0][1] ##1 !s.pin_sh[0][1];
    endsequence

    a_trig_flag: assert property ((mode == TM_RELOAD && !fast && !down_en && trig_ev
        && !sw_wr_ctrl) |=> s.ctrl[`TM_B_EXTF])
        else $error("trigger edge did not set external flag");

    a_irq_raise: assert property ((irq_enable_i && s.ctrl[`TM_B_OVF] && !sw_wr_ctrl)
        |=> timer_irq_o)
        else $error("interrupt not raised for overflow flag");

    a_down_quiet: assert property ((s.mode_reg[`TM_B_DOWN] && !s.ctrl[`TM_B_OVF]
        && !tf_set && !wr_en) |=> !timer_irq_o)
        else $error("external flag raised interrupt in up down mode");

    a_dn_reload: assert property ((mode == TM_RELOAD && !fast && down_en && ovf
        && !sw_wr_cnt) |=> s.count == $past(s.reload))
        else $error("up overflow in up down mode did not reload");

    a_oe_follow: assert property (clkout |=> clock_out_pin_oe_o)
        else $error("clock out drive not enabled");

    a_baud_tick: assert property (s_baud_roll |=> baud_tick_o)
        else $error("baud rollover gave no tick");

    a_baud_quiet: assert property ((baud && ovf && !sw_wr_ctrl && !s.ctrl[`TM_B_OVF])
        |=> !s.ctrl[`TM_B_OVF])
        else $error("baud rollover set overflow flag");

    a_trig_edge: assert property (s_trig_drop |-> fall[0])
        else $error("trigger falling edge not detected");
endmodule

// ===== tb/tm_pins.sv
`timescale 1ns/100ps
module tm_pins (
    input wire logic clk_i,
    output logic trig_o,
    output logic cnt_o
);
    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    // Both pins idle high; each level lasts 4 clocks, above the 2-clock minimum
    initial
    begin
        trig_o = 1'b1;
        cnt_o = 1'b1;
    end

    // Count edges go onto the shared pin while the timer is not driving it
    task count_pulse(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            cnt_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            cnt_o <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
    endtask

    task trig_fall();
        @(posedge clk_i);
        trig_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        trig_o <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask

    // Direction level needs the synchroniser to settle before counting
    task set_dir(input logic v);
        @(posedge clk_i);
        trig_o <= v;
        repeat (6) @(posedge clk_i);
    endtask
endmodule

// ===== tb/timer2_capture_reload_clockout_test.sv
`timescale 1ns/100ps
`include "tm_consts.svh"
module timer2_capture_reload_clockout_test;
    logic clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready, irq_en;
    logic awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, irq, btick;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic trig, cnt;
    wire logic pin;
    int mismatches, total_checks, hi, lo, n;

    // Shared pin: the timer output wins while enabled, else the count source
    assign pin = pin_oe ? pin_o : cnt;

    tm_top dut (.clk_i(clk_i), .rst_i(rst_i), .awvalid_i(awvalid), .awready_o(awready),
        .awaddr_i(awaddr), .wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata),
        .wstrb_i(wstrb), .bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp),
        .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr), .rvalid_o(rvalid),
        .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp), .ext_trig_i(trig),
        .clock_out_pin_i(pin), .clock_out_pin_o(pin_o), .clock_out_pin_oe_o(pin_oe),
        .irq_enable_i(irq_en), .timer_irq_o(irq), .baud_tick_o(btick));

    tm_pins pins (.clk_i(clk_i), .trig_o(trig), .cnt_o(cnt));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input logic [34:0] got, input logic [34:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0,
        input logic [3:0] st = 4'h1);
        @(posedge clk_i);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wstrb <= st;
        bready <= 1'b1;
        forever
        begin
            @(posedge clk_i);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
        chk({32'h0, bvalid, bresp}, {32'h0, 1'b1, er});
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        @(posedge clk_i);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        forever
        begin
            @(posedge clk_i);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rready <= 1'b0;
        rv = rdata;
        chk({rvalid, rresp, rdata}, {1'b1, er, e});
    endtask

    task chk_irq(input logic e);
        repeat (2) @(posedge clk_i);
        chk({34'h0, irq}, {34'h0, e});
    endtask

    // Pin level is read just after each edge, so it holds the settled value
    task per();
        repeat (20)
        begin
            @(posedge clk_i);
            if (pin_o === 1'b0)
                break;
        end
        repeat (20)
        begin
            @(posedge clk_i);
            if (pin_o === 1'b1)
                break;
        end
        hi = 0;
        while (pin_o === 1'b1 && hi < 20)
        begin
            @(posedge clk_i);
            hi++;
        end
        lo = 0;
        while (pin_o === 1'b0 && lo < 20)
        begin
            @(posedge clk_i);
            lo++;
        end
    endtask

    task end_of_test();
        $display("Checks: %0d, mismatches: %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Run is well under a thousand cycles; the limit leaves wide margin
    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'h0;
        irq_en = 1'b1;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`TM_OFF_CTRL, 32'h00);
        rd(`TM_OFF_MODE, 32'h00);
        rd(8'h18, 32'h00, 2'h2);
        wr(8'h1c, 8'h55, 2'h2);
        wr(`TM_OFF_RELL, 8'h5a);
        rd(`TM_OFF_RELL, 32'h5a);
        // Low strobe clear: answered, register untouched
        wr(`TM_OFF_RELL, 8'ha5, 2'h0, 4'h0);
        rd(`TM_OFF_RELL, 32'h5a);
        // Capture with trigger enabled, counting pin edges
        wr(`TM_OFF_CNTL, 8'h34);
        wr(`TM_OFF_CNTH, 8'h12);
        wr(`TM_OFF_CTRL, 8'h0f);
        pins.count_pulse(3);
        pins.trig_fall();
        rd(`TM_OFF_RELL, 32'h37);
        rd(`TM_OFF_RELH, 32'h12);
        rd(`TM_OFF_CTRL, 32'h4f);
        chk_irq(1'b1);
        irq_en <= 1'b0;
        chk_irq(1'b0);
        irq_en <= 1'b1;
        pins.count_pulse(1);
        rd(`TM_OFF_CNTL, 32'h38);
        rd(`TM_OFF_CNTH, 32'h12);
        // Up reload: overflow, then trigger reload
        wr(`TM_OFF_CTRL, 8'h00);
        wr(`TM_OFF_RELL, 8'hf0);
        wr(`TM_OFF_RELH, 8'hff);
        wr(`TM_OFF_CNTL, 8'hfe);
        wr(`TM_OFF_CNTH, 8'hff);
        wr(`TM_OFF_CTRL, 8'h06);
        pins.count_pulse(2);
        rd(`TM_OFF_CNTL, 32'hf0);
        rd(`TM_OFF_CNTH, 32'hff);
        rd(`TM_OFF_CTRL, 32'h86);
        chk_irq(1'b1);
        wr(`TM_OFF_CTRL, 8'h06);
        chk_irq(1'b0);
        wr(`TM_OFF_CNTL, 8'h05);
        wr(`TM_OFF_CNTH, 8'h00);
        wr(`TM_OFF_CTRL, 8'h0e);
        pins.trig_fall();
        rd(`TM_OFF_CNTL, 32'hf0);
        rd(`TM_OFF_CNTH, 32'hff);
        rd(`TM_OFF_CTRL, 32'h4e);
        // Up/down: underflow at the reload value, then overflow upward
        wr(`TM_OFF_CTRL, 8'h00);
        wr(`TM_OFF_MODE, 8'h01);
        pins.set_dir(1'b0);
        wr(`TM_OFF_CNTL, 8'h10);
        wr(`TM_OFF_CNTH, 8'h00);
        wr(`TM_OFF_RELL, 8'h10);
        wr(`TM_OFF_RELH, 8'h00);
        wr(`TM_OFF_CTRL, 8'h06);
        pins.count_pulse(1);
        rd(`TM_OFF_CNTL, 32'hff);
        rd(`TM_OFF_CNTH, 32'hff);
        rd(`TM_OFF_CTRL, 32'hc6);
        wr(`TM_OFF_CTRL, 8'h46);
        chk_irq(1'b0);
        pins.set_dir(1'b1);
        pins.count_pulse(1);
        rd(`TM_OFF_CNTL, 32'h10);
        rd(`TM_OFF_CTRL, 32'h86);
        // Run spans 240 edges from start write to stop write, so exactly 20 ticks
        wr(`TM_OFF_CTRL, 8'h00);
        wr(`TM_OFF_MODE, 8'h00);
        wr(`TM_OFF_CNTL, 8'h00);
        wr(`TM_OFF_CNTH, 8'h00);
        wr(`TM_OFF_CTRL, 8'h04);
        repeat (236) @(posedge clk_i);
        wr(`TM_OFF_CTRL, 8'h00);
        rd(`TM_OFF_CNTL, 32'h14);
        chk({34'h0, rv[7:0] == 8'd20}, 35'h1);
        repeat (48) @(posedge clk_i);
        rd(`TM_OFF_CNTL, rv);
        // Clock out, alone and beside baud generation
        wr(`TM_OFF_MODE, 8'h02);
        wr(`TM_OFF_RELL, 8'hfe);
        wr(`TM_OFF_RELH, 8'hff);
        wr(`TM_OFF_CNTL, 8'hfe);
        wr(`TM_OFF_CNTH, 8'hff);
        wr(`TM_OFF_CTRL, 8'h04);
        chk({34'h0, pin_oe}, 35'h1);
        per();
        chk({3'h0, hi[15:0], lo[15:0]}, {3'h0, 16'd4, 16'd4});
        rd(`TM_OFF_CTRL, 32'h04);
        chk_irq(1'b0);
        wr(`TM_OFF_CTRL, 8'h14);
        n = 0;
        // First sample still shows the tick state from before baud mode
        repeat (41)
        begin
            @(posedge clk_i);
            if (btick === 1'b1)
                n++;
        end
        per();
        chk({3'h0, n[15:0], hi[7:0], lo[7:0]}, {3'h0, 16'd10, 8'd4, 8'd4});
        // Reset again mid-run: registers and pin drive return to idle
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`TM_OFF_MODE, 32'h00);
        rd(`TM_OFF_CTRL, 32'h00);
        chk({34'h0, pin_oe}, 35'h0);
        end_of_test();
    end
endmodule
